// >>> design/iq_corr_pkg.sv
package iq_corr_pkg;

  // **
  // Bus geometry
  // **
  localparam int          AXI_ADDR_W   = 8;
  localparam int          AXI_DATA_W   = 32;
  localparam int          REG_W        = 16;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // **
  // Register indices (byte address = 4 * index)
  // **
  localparam logic [5:0]  IDX_CHAN_A_SCALE    = 6'h0c;
  localparam logic [5:0]  IDX_CHAN_B_SCALE    = 6'h0d;
  localparam logic [5:0]  IDX_DELAY_D_GAIN    = 6'h0f;
  localparam logic [5:0]  IDX_AB_SKEW         = 6'h10;
  localparam logic [5:0]  IDX_SYNC_ENABLE     = 6'h1e;
  localparam logic [5:0]  IDX_ACTIVE_STATUS   = 6'h20;

  // **
  // Reset values
  // **
  localparam logic [15:0] RST_CHAN_A_SCALE    = 16'h0400;
  localparam logic [15:0] RST_CHAN_B_SCALE    = 16'h0400;
  localparam logic [15:0] RST_DELAY_D_GAIN    = 16'h0400;
  localparam logic [15:0] RST_AB_SKEW         = 16'h0000;
  localparam logic [15:0] RST_SYNC_ENABLE     = 16'h0001;

  // **
  // Field positions and write masks
  // **
  localparam int          GAIN_W        = 11;
  localparam int          GAIN_MSB      = 10;
  localparam int          SKEW_W        = 12;
  localparam int          SKEW_MSB      = 11;
  localparam int          AB_LAT_MSB    = 15;
  localparam int          AB_LAT_LSB    = 14;
  localparam int          CD_LAT_MSB    = 13;
  localparam int          CD_LAT_LSB    = 12;
  localparam int          SYNC_EN_BIT   = 0;
  localparam int          STAT_FULL_BIT = 12;
  localparam logic [15:0] MASK_GAIN     = 16'h07ff;
  localparam logic [15:0] MASK_DELAY_D  = 16'hf7ff;
  localparam logic [15:0] MASK_SKEW     = 16'h0fff;
  localparam logic [15:0] MASK_SYNC     = 16'h0001;

  // **
  // Datapath arithmetic
  // **
  localparam int          SMP_W         = 16;
  localparam int          GAIN_FRAC     = 10;
  localparam int          SKEW_FRAC     = 12;
  localparam int          MAX_LATENCY   = 3;
  localparam int          WORD_W        = 4 * SMP_W;

endpackage : iq_corr_pkg

// >>> design/two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 64
) (
  input  wire logic             ref_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  logic [WIDTH-1:0] second_q;
  logic [1:0]       count_q;
  logic [1:0]       count_d;
  logic             push;
  logic             pop;

  assign push = ce_in && in_valid_in && in_ready_out;
  assign pop  = ce_in && out_valid_out && out_ready_in;

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q       <= 2'h0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      count_q       <= count_d;
      in_ready_out  <= (count_d != 2'h2);
      out_valid_out <= (count_d != 2'h0);
    end
  end

  // Head holds the oldest word, second the younger one
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_data_out <= '0;
      second_q     <= '0;
    end else begin
      if (pop) begin
        if (count_q == 2'h2) begin
          out_data_out <= second_q;
          if (push) begin
            second_q <= in_data_in;
          end
        end else if (push) begin
          out_data_out <= in_data_in;
        end
      end else if (push) begin
        if (count_q == 2'h0) begin
          out_data_out <= in_data_in;
        end else begin
          second_q <= in_data_in;
        end
      end
    end
  end

endmodule : two_entry_buffer

// >>> design/iq_gain_phase_correction.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: AB outputs delayed 0-3 cycles, bits 15:14
// RULE2: CD outputs delayed 0-3 cycles, bits 13:12
// RULE3: Channel D gain 11-bit unsigned, unity reset
// RULE4: AB skew coefficient 12-bit signed, half-scale
// RULE5: Skew coefficient resets to zero correction
// RULE6: A gets B times skew coefficient added
// RULE7: Skew write with sync enabled fires sync
// RULE8: Sync loads A, B gains and skew together
// RULE9: Gain writes alone leave active settings
// RULE10: Software writes skew register after both gains
// RULE11: Channel A gain 11-bit unsigned, own register
// RULE12: Channel B gain 11-bit unsigned, bits 10:0
// RULE13: Gains scale samples each clock, saturate
module iq_gain_phase_correction
  import iq_corr_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  ce_in,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  // Sample stream in
  input  wire logic [SMP_W-1:0]      smp_a_in,
  input  wire logic [SMP_W-1:0]      smp_b_in,
  input  wire logic [SMP_W-1:0]      smp_c_in,
  input  wire logic [SMP_W-1:0]      smp_d_in,
  input  wire logic                  smp_valid_in,
  output logic                       smp_ready_out,
  // Sample stream out
  output logic [SMP_W-1:0]           out_a_out,
  output logic [SMP_W-1:0]           out_b_out,
  output logic [SMP_W-1:0]           out_c_out,
  output logic [SMP_W-1:0]           out_d_out,
  output logic                       out_valid_out,
  input  wire logic                  out_ready_in
);

  typedef enum logic [1:0] {
    WR_ADDR_DATA = 2'b00,
    WR_RESPOND   = 2'b01
  } wr_state_t;

  // **
  // Bus slave state
  // **
  wr_state_t             wr_state_q;
  logic                  aw_held_q;
  logic                  w_held_q;
  logic [5:0]            aw_idx_q;
  logic [AXI_DATA_W-1:0] wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_fire;
  logic [15:0]           strb_mask;
  logic                  wr_hit;

  // **
  // Registers
  // **
  logic [15:0]           chan_a_scale_reg_q;
  logic [15:0]           chan_b_scale_reg_q;
  logic [15:0]           delay_d_gain_reg_q;
  logic [15:0]           ab_skew_reg_q;
  logic [15:0]           correction_sync_enable_reg_q;
  logic [GAIN_W-1:0]     act_gain_a_q;
  logic [GAIN_W-1:0]     act_gain_b_q;
  logic [SKEW_W-1:0]     act_skew_q;
  logic                  sync_pulse;
  logic                  sync_enabled;

  // **
  // Datapath state
  // **
  logic                  step;
  logic                  buf_ready;
  logic                  buf_full;
  logic [SMP_W-1:0]      s1_a_q;
  logic [SMP_W-1:0]      s1_b_q;
  logic [SMP_W-1:0]      s1_c_q;
  logic [SMP_W-1:0]      s1_d_q;
  logic                  s1_v_q;
  logic [2*SMP_W:0]      ab_line_q [MAX_LATENCY];
  logic [2*SMP_W-1:0]    cd_line_q [MAX_LATENCY];
  logic [2*SMP_W:0]      ab_sel;
  logic [2*SMP_W-1:0]    cd_sel;
  logic [1:0]            ab_path_output_latency;
  logic [1:0]            cd_path_output_latency;
  logic [WORD_W-1:0]     out_word;

  function automatic logic [SMP_W-1:0] sat16(input logic signed [19:0] v);
    logic signed [19:0] hi;
    logic signed [19:0] lo;
    hi = 20'sh07fff;
    lo = -20'sh08000;
    if (v > hi) begin
      sat16 = 16'h7fff;
    end else if (v < lo) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[SMP_W-1:0];
    end
  endfunction : sat16

  function automatic logic signed [19:0] gain_mul(input logic [SMP_W-1:0] s,
                                                  input logic [GAIN_W-1:0] g);
    logic signed [28:0] p;
    p = $signed(s) * $signed({1'b0, g});
    gain_mul = 20'(p >>> GAIN_FRAC);
  endfunction : gain_mul

  // **
  // Write channel
  // **
  assign wr_fire   = (wr_state_q == WR_ADDR_DATA) && aw_held_q && w_held_q && ce_in;
  assign strb_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_hit    = (aw_idx_q == IDX_CHAN_A_SCALE) || (aw_idx_q == IDX_CHAN_B_SCALE) ||
                     (aw_idx_q == IDX_DELAY_D_GAIN) || (aw_idx_q == IDX_AB_SKEW) ||
                     (aw_idx_q == IDX_SYNC_ENABLE);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held_q         <= 1'b0;
      aw_idx_q          <= 6'h00;
      s_axi_awready_out <= 1'b1;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q         <= 1'b1;
        aw_idx_q          <= s_axi_awaddr_in[7:2];
        s_axi_awready_out <= 1'b0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        aw_held_q         <= 1'b0;
        s_axi_awready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      w_held_q         <= 1'b0;
      wdata_q          <= '0;
      wstrb_q          <= 4'h0;
      s_axi_wready_out <= 1'b1;
    end else if (ce_in) begin
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q         <= 1'b1;
        wdata_q          <= s_axi_wdata_in;
        wstrb_q          <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        w_held_q         <= 1'b0;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_state_q       <= WR_ADDR_DATA;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (ce_in) begin
      case (wr_state_q)
        WR_ADDR_DATA: begin
          if (wr_fire) begin
            wr_state_q       <= WR_RESPOND;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESPOND: begin
          if (s_axi_bready_in) begin
            wr_state_q       <= WR_ADDR_DATA;
            s_axi_bvalid_out <= 1'b0;
          end
        end
        default: begin
          wr_state_q       <= WR_ADDR_DATA;
          s_axi_bvalid_out <= 1'b0;
        end
      endcase
    end
  end

  // **
  // Staged registers
  // **
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chan_a_scale_reg_q           <= RST_CHAN_A_SCALE;
      chan_b_scale_reg_q           <= RST_CHAN_B_SCALE;
      delay_d_gain_reg_q           <= RST_DELAY_D_GAIN; // RULE1 RULE2 RULE3
      ab_skew_reg_q                <= RST_AB_SKEW; // RULE5
      correction_sync_enable_reg_q <= RST_SYNC_ENABLE;
    end else if (wr_fire) begin
      case (aw_idx_q)
        IDX_CHAN_A_SCALE: begin
          chan_a_scale_reg_q <= (chan_a_scale_reg_q & ~strb_mask) |
                                (wdata_q[15:0] & strb_mask & MASK_GAIN); // RULE11
        end
        IDX_CHAN_B_SCALE: begin
          chan_b_scale_reg_q <= (chan_b_scale_reg_q & ~strb_mask) |
                                (wdata_q[15:0] & strb_mask & MASK_GAIN); // RULE12
        end
        IDX_DELAY_D_GAIN: begin
          delay_d_gain_reg_q <= (delay_d_gain_reg_q & ~strb_mask) |
                                (wdata_q[15:0] & strb_mask & MASK_DELAY_D); // RULE3
        end
        IDX_AB_SKEW: begin
          ab_skew_reg_q <= (ab_skew_reg_q & ~strb_mask) |
                           (wdata_q[15:0] & strb_mask & MASK_SKEW); // RULE4
        end
        IDX_SYNC_ENABLE: begin
          correction_sync_enable_reg_q <= (correction_sync_enable_reg_q & ~strb_mask) |
                                          (wdata_q[15:0] & strb_mask & MASK_SYNC);
        end
        default: begin
          ab_skew_reg_q <= ab_skew_reg_q;
        end
      endcase
    end
  end

  // **
  // Auto-sync load of active settings
  // **
  assign sync_enabled = correction_sync_enable_reg_q[SYNC_EN_BIT];
  assign sync_pulse   = wr_fire && (aw_idx_q == IDX_AB_SKEW) && sync_enabled; // RULE7

  // With sync disabled the staged values act directly
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      act_gain_a_q <= RST_CHAN_A_SCALE[GAIN_MSB:0];
      act_gain_b_q <= RST_CHAN_B_SCALE[GAIN_MSB:0];
      act_skew_q   <= RST_AB_SKEW[SKEW_MSB:0]; // RULE5
    end else if (sync_pulse) begin
      act_gain_a_q <= chan_a_scale_reg_q[GAIN_MSB:0]; // RULE8
      act_gain_b_q <= chan_b_scale_reg_q[GAIN_MSB:0]; // RULE8
      act_skew_q   <= (ab_skew_reg_q[SKEW_MSB:0] & ~strb_mask[SKEW_MSB:0]) |
                      (wdata_q[SKEW_MSB:0] & strb_mask[SKEW_MSB:0]); // RULE8
    end else if (!sync_enabled && ce_in) begin
      act_gain_a_q <= chan_a_scale_reg_q[GAIN_MSB:0];
      act_gain_b_q <= chan_b_scale_reg_q[GAIN_MSB:0];
      act_skew_q   <= ab_skew_reg_q[SKEW_MSB:0];
    end
  end
  // Gain writes alone never reach the active copies while sync is on  RULE9

  // **
  // Read channel
  // **
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= RESP_OKAY;
        case (s_axi_araddr_in[7:2])
          IDX_CHAN_A_SCALE:  s_axi_rdata_out <= {16'h0000, chan_a_scale_reg_q};
          IDX_CHAN_B_SCALE:  s_axi_rdata_out <= {16'h0000, chan_b_scale_reg_q};
          IDX_DELAY_D_GAIN:  s_axi_rdata_out <= {16'h0000, delay_d_gain_reg_q};
          IDX_AB_SKEW:       s_axi_rdata_out <= {16'h0000, ab_skew_reg_q};
          IDX_SYNC_ENABLE:   s_axi_rdata_out <= {16'h0000, correction_sync_enable_reg_q};
          IDX_ACTIVE_STATUS: begin
            s_axi_rdata_out <= {19'h00000, buf_full, act_skew_q};
          end
          default: begin
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // **
  // Correction stage
  // **
  assign step          = ce_in && buf_ready;
  assign smp_ready_out = buf_ready;
  assign buf_full      = !buf_ready;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_a_q <= '0;
      s1_b_q <= '0;
      s1_c_q <= '0;
      s1_d_q <= '0;
      s1_v_q <= 1'b0;
    end else if (step) begin
      s1_a_q <= sat16(gain_mul(smp_a_in, act_gain_a_q) + // RULE6 RULE13
                      20'((28'($signed(smp_b_in)) * $signed(act_skew_q)) >>> SKEW_FRAC));
      s1_b_q <= sat16(gain_mul(smp_b_in, act_gain_b_q)); // RULE13
      s1_c_q <= smp_c_in;
      s1_d_q <= sat16(gain_mul(smp_d_in, delay_d_gain_reg_q[GAIN_MSB:0])); // RULE3 RULE13
      s1_v_q <= smp_valid_in;
    end
  end

  // **
  // Output latency lines
  // **
  assign ab_path_output_latency = delay_d_gain_reg_q[AB_LAT_MSB:AB_LAT_LSB];
  assign cd_path_output_latency = delay_d_gain_reg_q[CD_LAT_MSB:CD_LAT_LSB];

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < MAX_LATENCY; i++) begin
        ab_line_q[i] <= '0;
        cd_line_q[i] <= '0;
      end
    end else if (step) begin
      ab_line_q[0] <= {s1_v_q, s1_a_q, s1_b_q};
      cd_line_q[0] <= {s1_c_q, s1_d_q};
      for (int i = 1; i < MAX_LATENCY; i++) begin
        ab_line_q[i] <= ab_line_q[i-1];
        cd_line_q[i] <= cd_line_q[i-1];
      end
    end
  end

  always_comb begin
    if (ab_path_output_latency == 2'h0) begin
      ab_sel = {s1_v_q, s1_a_q, s1_b_q}; // RULE1
    end else begin
      ab_sel = ab_line_q[ab_path_output_latency - 2'h1]; // RULE1
    end
    if (cd_path_output_latency == 2'h0) begin
      cd_sel = {s1_c_q, s1_d_q}; // RULE2
    end else begin
      cd_sel = cd_line_q[cd_path_output_latency - 2'h1]; // RULE2
    end
  end

  // **
  // Output buffer
  // **
  two_entry_buffer #(
    .WIDTH (WORD_W)
  ) u_out_buffer (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .ce_in         (ce_in),
    .in_valid_in   (ab_sel[2*SMP_W]),
    .in_ready_out  (buf_ready),
    .in_data_in    ({ab_sel[2*SMP_W-1:0], cd_sel}),
    .out_valid_out (out_valid_out),
    .out_ready_in  (out_ready_in),
    .out_data_out  (out_word)
  );

  assign out_a_out = out_word[4*SMP_W-1:3*SMP_W];
  assign out_b_out = out_word[3*SMP_W-1:2*SMP_W];
  assign out_c_out = out_word[2*SMP_W-1:SMP_W];
  assign out_d_out = out_word[SMP_W-1:0];

endmodule : iq_gain_phase_correction

// >>> tb/iq_corr_sva.sv
`timescale 1ns/1ps
module iq_corr_sva
  import iq_corr_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        nrst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        smp_valid_in,
  input wire logic        smp_ready_out,
  input wire logic [15:0] out_a_out,
  input wire logic [15:0] out_c_out,
  input wire logic        out_valid_out,
  input wire logic        out_ready_in
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_wr_resp;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> ##1 s_axi_bvalid_out;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_b_done;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out && s_axi_awready_out
      && s_axi_wready_out;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write channel not reopened");
  property p_aw_block;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_rd_resp;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  property p_r_done;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read channel not reopened");
  property p_bad_rd;
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:2] > 6'h20
      |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
  property p_out_hold;
    out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_a_out)
      && $stable(out_c_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled word changed");
  property p_full;
    !smp_ready_out |-> out_valid_out;
  endproperty
  a_full: assert property (p_full) else $error("input stalled with no output");
  property p_latency;
    smp_valid_in && smp_ready_out ##1 out_ready_in [*5] |-> out_valid_out
      || $past(out_valid_out) || $past(out_valid_out, 2) || $past(out_valid_out, 3);
  endproperty
  a_latency: assert property (p_latency) else $error("sample too late");
endmodule : iq_corr_sva

bind iq_gain_phase_correction iq_corr_sva u_sva (.*);

// >>> tb/iq_upstream_model.sv
`timescale 1ns/1ps
module iq_upstream_model
  import iq_corr_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        go_in,
  input  wire logic [7:0]  count_in,
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] b_in,
  input  wire logic [15:0] d_in,
  input  wire logic        smp_ready_in,
  output logic      [15:0] smp_a_out,
  output logic      [15:0] smp_b_out,
  output logic      [15:0] smp_c_out,
  output logic      [15:0] smp_d_out,
  output logic             smp_valid_out,
  output logic             busy_out
);
  logic [7:0] left_q = 8'h00;

  initial smp_valid_out = 1'b0;
  assign busy_out = (left_q != 8'h00);

  // Burst of count_in words, C counts up from 1
  always @(posedge ref_clk_in) begin
    if (smp_valid_out && smp_ready_in && left_q == 8'h01) begin
      smp_valid_out <= 1'b0;
      left_q <= 8'h00;
      {smp_a_out, smp_b_out, smp_c_out, smp_d_out} <=
        ~{smp_a_out, smp_b_out, smp_c_out, smp_d_out};
    end else if (smp_valid_out && smp_ready_in) begin
      left_q <= left_q - 8'h01;
      smp_c_out <= smp_c_out + 16'h0001;
    end else if (go_in && !busy_out) begin
      smp_valid_out <= 1'b1;
      left_q <= count_in;
      {smp_a_out, smp_b_out, smp_c_out, smp_d_out} <= {a_in, b_in, 16'h0001, d_in};
    end
  end
endmodule : iq_upstream_model

// >>> tb/iq_gain_phase_correction_bench.sv
`timescale 1ns/1ps
module iq_gain_phase_correction_bench
  import iq_corr_pkg::*;
;
  logic        ref_clk_in, nrst_in, ce_in, go, busy;
  logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic        s_axi_rvalid_out, s_axi_rready_in, smp_valid_in, smp_ready_out;
  logic        out_valid_out, out_ready_in;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [15:0] smp_a_in, smp_b_in, smp_c_in, smp_d_in, ma, mb, md;
  logic [15:0] out_a_out, out_b_out, out_c_out, out_d_out;
  logic [15:0] qa[$], qb[$], qc[$], qd[$];
  logic [7:0]  cnt;
  int          n_errors, n_checks, cyc, t_in, t_out;

  iq_gain_phase_correction DUT (.*);
  iq_upstream_model u_model (.ref_clk_in(ref_clk_in), .go_in(go), .count_in(cnt), .a_in(ma),
    .b_in(mb), .d_in(md), .smp_ready_in(smp_ready_out), .smp_a_out(smp_a_in),
    .smp_b_out(smp_b_in), .smp_c_out(smp_c_in), .smp_d_out(smp_d_in),
    .smp_valid_out(smp_valid_in), .busy_out(busy));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (smp_valid_in && smp_ready_out && t_in < 0) t_in = cyc;
    if (out_valid_out && out_ready_in) begin
      if (t_out < 0) t_out = cyc;
      qa.push_back(out_a_out);
      qb.push_back(out_b_out);
      qc.push_back(out_c_out);
      qd.push_back(out_d_out);
    end
  end

  // **
  // Shared tasks
  // **
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [5:0] idx, input logic [15:0] v, input logic [1:0] er);
    s_axi_awaddr_in <= {idx, 2'h0};
    s_axi_wdata_in <= {16'h0000, v};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    fork
      begin
        do @(posedge ref_clk_in); while (!s_axi_awready_out);
        s_axi_awvalid_in <= 1'b0;
      end
      begin
        do @(posedge ref_clk_in); while (!s_axi_wready_out);
        s_axi_wvalid_in <= 1'b0;
      end
    join
    do @(posedge ref_clk_in); while (!s_axi_bvalid_out);
    chk({30'h0, s_axi_bresp_out}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr_in <= {idx, 2'h0};
    s_axi_arvalid_in <= 1'b1;
    do @(posedge ref_clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge ref_clk_in); while (!s_axi_rvalid_out);
    chk(s_axi_rdata_out, exp, "read data");
    chk({30'h0, s_axi_rresp_out}, {30'h0, er}, "read response");
  endtask : rd

  task automatic run(input logic [7:0] n);
    qa.delete();
    qb.delete();
    qc.delete();
    qd.delete();
    t_in = -1;
    t_out = -1;
    cnt <= n;
    go <= 1'b1;
    @(posedge ref_clk_in);
    go <= 1'b0;
    for (int i = 0; i < 60 && qa.size() < n; i++) @(posedge ref_clk_in);
  endtask : run

  // **
  // Scenarios
  // **
  task automatic t_regs();
    rd(IDX_CHAN_A_SCALE, 32'h0400, RESP_OKAY);
    rd(IDX_CHAN_B_SCALE, 32'h0400, RESP_OKAY);
    rd(IDX_DELAY_D_GAIN, 32'h0400, RESP_OKAY);
    rd(IDX_AB_SKEW, 32'h0, RESP_OKAY);
    rd(IDX_ACTIVE_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_DELAY_D_GAIN, 16'hffff, RESP_OKAY);
    rd(IDX_DELAY_D_GAIN, 32'hf7ff, RESP_OKAY);
    wr(IDX_AB_SKEW, 16'hffff, RESP_OKAY);
    rd(IDX_AB_SKEW, 32'h0fff, RESP_OKAY);
    wr(6'h3f, 16'h1234, RESP_SLVERR);
    rd(6'h3f, 32'h0, RESP_SLVERR);
    wr(IDX_AB_SKEW, 16'h0000, RESP_OKAY);
  endtask : t_regs

  task automatic t_gain();
    ma <= 16'h0064;
    mb <= 16'h1000;
    md <= 16'h03e8;
    wr(IDX_DELAY_D_GAIN, 16'h0200, RESP_OKAY);
    run(8'h01);
    chk(qa[0], 16'h0064, "A with zero skew");
    chk(qb[0], 16'h1000, "B unity");
    chk(qd[0], 16'h01f4, "D half");
    md <= 16'h9000;
    wr(IDX_DELAY_D_GAIN, 16'h07ff, RESP_OKAY);
    run(8'h01);
    chk(qd[0], 16'h8000, "D low clip");
  endtask : t_gain

  task automatic t_sync();
    wr(IDX_CHAN_A_SCALE, 16'h0200, RESP_OKAY);
    wr(IDX_CHAN_B_SCALE, 16'h0600, RESP_OKAY);
    run(8'h01);
    chk(qa[0], 16'h0064, "A gain applied early");
    chk(qb[0], 16'h1000, "B gain applied early");
    wr(IDX_AB_SKEW, 16'h0400, RESP_OKAY);
    rd(IDX_ACTIVE_STATUS, 32'h0400, RESP_OKAY);
    run(8'h01);
    chk(qa[0], 16'h0432, "A gain plus skew");
    chk(qb[0], 16'h1800, "B gain");
    wr(IDX_AB_SKEW, 16'h0c00, RESP_OKAY);
    run(8'h01);
    chk(qa[0], 16'hfc32, "negative skew");
    wr(IDX_SYNC_ENABLE, 16'h0000, RESP_OKAY);
    wr(IDX_CHAN_B_SCALE, 16'h0400, RESP_OKAY);
    run(8'h01);
    chk(qb[0], 16'h1000, "B direct");
  endtask : t_sync

  task automatic t_delay();
    for (int l = 0; l < 4; l++) begin
      wr(IDX_DELAY_D_GAIN, {l[1:0], l[1:0], 12'h400}, RESP_OKAY);
      run(8'h01);
      chk(t_out - t_in, l + 2, "latency");
      chk(qc[0], 16'h0001, "CD alignment");
    end
    wr(IDX_DELAY_D_GAIN, 16'h8400, RESP_OKAY);
    run(8'h03);
    chk(qc[0], 16'h0003, "CD offset pairing");
  endtask : t_delay

  task automatic t_buffer();
    wr(IDX_DELAY_D_GAIN, 16'h0400, RESP_OKAY);
    out_ready_in <= 1'b0;
    run(8'h06);
    chk(smp_ready_out, 1'b0, "no stall");
    rd(IDX_ACTIVE_STATUS, 32'h1c00, RESP_OKAY);
    out_ready_in <= 1'b1;
    for (int i = 0; i < 60 && qc.size() < 6; i++) @(posedge ref_clk_in);
    for (int i = 0; i < 6; i++) chk(qc[i], i + 1, "word order");
  endtask : t_buffer

  initial begin
    {nrst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in, go} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, cnt, ma, mb, md} = '0;
    {ce_in, s_axi_bready_in, s_axi_rready_in, out_ready_in} = 4'hf;
    s_axi_wstrb_in = 4'hf;
    {n_errors, n_checks, cyc, t_in, t_out} = '0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    t_regs();
    t_gain();
    t_sync();
    t_delay();
    t_buffer();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    end_of_test();
  end
endmodule : iq_gain_phase_correction_bench
